/* src/pmu_cfg.svh */
// How it works
// - answer only at 7-bit target address 0010010, ignore other frames
// - serial link works at fast-mode rates up to 400 kb/s
// - the dummy write of 00000000 to offset 0x0a has no effect
// - 0x03..0x06 reset on supply-low, or enable pin low with policy 1
// - charge registers reset on supply lows, or battery low with policy 1
// - backlight overvoltage level 16 V when 0, 25 V when 1
// - input power management on when bit set or charger type 000
// - thermal shutdown flag sticky; cleared by writing 0 or supply-low
// - 0x01 holds eight sticky channel protection flags
// - thermistor select picks 60/28 or 74/28 percent thresholds
// - backlight code 0 is off, else on with target code/31*0.25 V
// - manual mode: charge status pin hi-z at 1, low at 0
// - manual mode: second status pin hi-z at 1, low at 0
// - channel 5 code 0000 selects external feedback at 0.8 V
// - die over-temperature opens input path, battery path stays closed
// - status pin auto mode picks charging state or manual level
`ifndef PMU_CFG_SVH
`define PMU_CFG_SVH
`define PMU_I2C_ADDR 7'h12
`define PMU_OFS_CTRL 8'h00
`define PMU_OFS_PROT 8'h01
`define PMU_OFS_LDO 8'h02
`define PMU_OFS_CONV_LO 8'h03
`define PMU_OFS_CONV_HI 8'h06
`define PMU_OFS_STAT 8'h0a
`define PMU_RST_CTRL 8'h81
`define PMU_RST_PROT 8'h00
`define PMU_RST_LDO 8'h00
`define PMU_RST_CONV0 8'hfc
`define PMU_RST_CONV1 8'ha4
`define PMU_RST_CONV2 8'hcc
`define PMU_RST_CONV3 8'h83
`define PMU_CTRL_MASK 8'hed
`define PMU_B_RSTP 7
`define PMU_B_RSTC 6
`define PMU_B_OVP 5
`define PMU_B_DPM 3
`define PMU_B_SHUTDOWN 2
`define PMU_B_MODE 1
`define PMU_B_THERM_SEL 0
`define PMU_B_PIN1_LVL 7
`define PMU_B_PIN2_LVL 3
`define PMU_SDP_CODE 3'h0
`define PMU_CH5_EXT 4'h0
`define PMU_BL_OFF 5'h00
`define PMU_COLD_LO 7'h3c
`define PMU_COLD_HI 7'h4a
`define PMU_HOT_PCT 7'h1c
`define PMU_LAST_BIT 3'h7
`endif

/* src/pmu_pkg.sv */
package pmu_pkg;
  // protocol sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_REG, ST_ACK_REG,
    ST_WR, ST_ACK_WR, ST_RD, ST_RD_ACK
  } pmu_state_e;
  // converter settings seen by the analog side
  typedef struct packed {
    logic ch5_enable;
    logic ch6_enable;
    logic ch8_enable;
    logic [4:0] backlight_enable_dimming;
    logic [3:0] pulse_skip_auto_select;
    logic [3:0] ch8_voltage_code;
    logic [3:0] boost_voltage_code;
    logic ch1_enable;
    logic [2:0] ch2_reference_code;
    logic [2:0] ch3_reference_code;
    logic [2:0] ch4_reference_code;
    logic [3:0] ch5_voltage_code;
    logic [3:0] ch6_voltage_code;
  } pmu_ctrl_s;
endpackage

/* src/pmu_regbank.sv */
`timescale 1ns/1ps
`include "pmu_cfg.svh"
module pmu_regbank
  import pmu_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // serial link, open drain data
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // reset sources
  input wire logic internal_supply_low_i,
  input wire logic input_supply_low_i,
  input wire logic battery_low_i,
  input wire logic enable_pin_i,
  // events and analog status
  input wire logic thermal_shutdown_event_i,
  input wire logic [7:0] protect_event_i,
  input wire logic backlight_mode_result_i,
  input wire logic [2:0] charger_type_code_i,
  input wire logic die_over_temp_i,
  input wire logic die_cooled_i,
  // status pin sources
  input wire logic status_pin_auto_mode_i,
  input wire logic second_status_pin_auto_mode_i,
  input wire logic charge_state_low_i,
  input wire logic second_state_low_i,
  // converter controls
  output pmu_ctrl_s ctrl_o,
  output logic backlight_ovp_level_o,
  output logic backlight_on_o,
  output logic [4:0] backlight_fb_code_o,
  output logic ch5_ext_feedback_o,
  output logic input_power_mgmt_on_o,
  output logic [6:0] cold_ratio_pct_o,
  output logic [6:0] hot_ratio_pct_o,
  output logic input_path_open_o,
  output logic battery_path_closed_o,
  // status pins, open drain
  output logic charge_status_pin_o,
  output logic charge_status_pin_oe_o,
  output logic second_status_pin_o,
  output logic second_status_pin_oe_o
);

  // reset value of one converter register
  function automatic logic [7:0] conv_rst(input logic [1:0] idx);
    case (idx)
      2'h0: conv_rst = `PMU_RST_CONV0;
      2'h1: conv_rst = `PMU_RST_CONV1;
      2'h2: conv_rst = `PMU_RST_CONV2;
      default: conv_rst = `PMU_RST_CONV3;
    endcase
  endfunction

  // ************
  // link sampling
  // ************
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // inputs are synchronous, one stage is enough for edge detection
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // edges and bus conditions, fine for 400 kb/s at this rate
  assign scl_rise = scl_i & ~scl_q;
  assign scl_fall = ~scl_i & scl_q;
  assign bus_start = scl_i & scl_q & sda_q & ~sda_i;
  assign bus_stop = scl_i & scl_q & ~sda_q & sda_i;

  // ************
  // protocol sequencer
  // ************
  pmu_state_e state;
  logic [7:0] shreg;
  logic [7:0] byte_in;
  logic [7:0] ptr;
  logic [7:0] rd_data;
  logic [2:0] bit_cnt;
  logic slot;
  logic nack;
  logic drv;
  logic wr_pulse;

  assign byte_in = {shreg[6:0], sda_i};

  // a start always restarts, which also clears any confused state
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= ST_IDLE;
      shreg <= 8'h00;
      ptr <= 8'h00;
      bit_cnt <= 3'h0;
      slot <= 1'b0;
      nack <= 1'b0;
      drv <= 1'b0;
      wr_pulse <= 1'b0;
    end
    else
    begin
      wr_pulse <= 1'b0;
      // step the pointer only after the write decode has used it
      if (wr_pulse)
        ptr <= ptr + 8'h01;
      if (bus_start)
      begin
        state <= ST_ADDR;
        bit_cnt <= 3'h0;
        slot <= 1'b0;
        drv <= 1'b0;
      end
      else if (bus_stop)
      begin
        state <= ST_IDLE;
        drv <= 1'b0;
      end
      else
      begin
        case (state)
          ST_ADDR, ST_REG, ST_WR:
          begin
            if (scl_rise)
            begin
              shreg <= byte_in;
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == `PMU_LAST_BIT)
              begin
                if (state == ST_REG)
                  state <= ST_ACK_REG;
                else if (state == ST_WR)
                  state <= ST_ACK_WR;
                else if (byte_in[7:1] == `PMU_I2C_ADDR)
                  state <= ST_ACK_ADDR;
                else
                  state <= ST_IDLE;
              end
            end
          end
          ST_ACK_ADDR, ST_ACK_REG, ST_ACK_WR:
          begin
            if (scl_fall)
            begin
              slot <= ~slot;
              drv <= ~slot;
              if (slot)
              begin
                bit_cnt <= 3'h0;
                if (state == ST_ACK_REG)
                  ptr <= shreg;
                if (state == ST_ACK_WR)
                begin
                  wr_pulse <= 1'b1;
                end
                if (state == ST_ACK_ADDR && shreg[0])
                begin
                  state <= ST_RD;
                  shreg <= rd_data;
                  drv <= ~rd_data[7];
                end
                else
                  state <= (state == ST_ACK_ADDR) ? ST_REG : ST_WR;
              end
            end
          end
          ST_RD:
          begin
            if (scl_fall)
            begin
              shreg <= {shreg[6:0], 1'b0};
              drv <= ~shreg[6];
            end
            else if (scl_rise)
            begin
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == `PMU_LAST_BIT)
              begin
                state <= ST_RD_ACK;
                ptr <= ptr + 8'h01;
                slot <= 1'b0;
              end
            end
          end
          ST_RD_ACK:
          begin
            if (scl_rise)
              nack <= sda_i;
            if (scl_fall)
            begin
              slot <= ~slot;
              drv <= 1'b0;
              if (slot && nack)
                state <= ST_IDLE;
              else if (slot)
              begin
                state <= ST_RD;
                bit_cnt <= 3'h0;
                shreg <= rd_data;
                drv <= ~rd_data[7];
              end
            end
          end
          default:
            drv <= 1'b0;
        endcase
      end
    end
  end

  // open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = drv;

  // ************
  // register file
  // ************
  logic [7:0] reg_ctrl;
  logic [7:0] reg_prot;
  logic [7:0] reg_ldo;
  logic [7:0] reg_conv [0:3];
  logic conv_reset;
  logic chg_reset;
  logic wr_ctrl;
  logic wr_prot;

  // policy bits decide whether pin and battery conditions clear state
  assign conv_reset = internal_supply_low_i |
    (~enable_pin_i & reg_ctrl[`PMU_B_RSTP]);
  assign chg_reset = input_supply_low_i | internal_supply_low_i |
    (battery_low_i & reg_ctrl[`PMU_B_RSTC]);
  assign wr_ctrl = wr_pulse & (ptr == `PMU_OFS_CTRL);
  assign wr_prot = wr_pulse & (ptr == `PMU_OFS_PROT);

  // control register; the shutdown flag has its own clear path
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_ctrl <= `PMU_RST_CTRL;
    else
    begin
      if (chg_reset)
        reg_ctrl <= `PMU_RST_CTRL;
      else if (wr_ctrl)
        reg_ctrl <= shreg & `PMU_CTRL_MASK;
      // set beats a software clear in the same cycle
      if (thermal_shutdown_event_i)
        reg_ctrl[`PMU_B_SHUTDOWN] <= 1'b1;
      else if (internal_supply_low_i)
        reg_ctrl[`PMU_B_SHUTDOWN] <= 1'b0;
      else if (wr_ctrl)
        reg_ctrl[`PMU_B_SHUTDOWN] <= shreg[`PMU_B_SHUTDOWN];
      else
        reg_ctrl[`PMU_B_SHUTDOWN] <= reg_ctrl[`PMU_B_SHUTDOWN];
    end
  end

  // sticky protection flags; events win over writes of zero
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_prot <= `PMU_RST_PROT;
    else if (chg_reset)
      reg_prot <= `PMU_RST_PROT | protect_event_i;
    else if (wr_prot)
      reg_prot <= shreg | protect_event_i;
    else
      reg_prot <= reg_prot | protect_event_i;
  end

  // enables and dimming, cleared only on internal supply low
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_ldo <= `PMU_RST_LDO;
    else if (internal_supply_low_i)
      reg_ldo <= `PMU_RST_LDO;
    else if (wr_pulse && ptr == `PMU_OFS_LDO)
      reg_ldo <= shreg;
  end

  // converter registers; a write to the status offset lands nowhere
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < 4; i++)
        reg_conv[i] <= conv_rst(2'(i));
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (conv_reset)
          reg_conv[i] <= conv_rst(2'(i));
        else if (wr_pulse && ptr == `PMU_OFS_CONV_LO + 8'(i))
          reg_conv[i] <= shreg;
      end
    end
  end

  // read data; unmapped offsets and reserved bits read zero
  always_comb
  begin
    rd_data = 8'h00;
    case (ptr)
      `PMU_OFS_CTRL:
      begin
        rd_data = reg_ctrl;
        rd_data[`PMU_B_MODE] = backlight_mode_result_i;
      end
      `PMU_OFS_PROT: rd_data = reg_prot;
      `PMU_OFS_LDO: rd_data = reg_ldo;
      default:
      begin
        // converter block is contiguous, everything else reads zero
        if (ptr >= `PMU_OFS_CONV_LO && ptr <= `PMU_OFS_CONV_HI)
          rd_data = reg_conv[2'(ptr - `PMU_OFS_CONV_LO)];
      end
    endcase
  end

  // field map onto the converter side
  assign ctrl_o = '{
    ch5_enable: reg_ldo[7],
    ch6_enable: reg_ldo[6],
    ch8_enable: reg_ldo[5],
    backlight_enable_dimming: reg_ldo[4:0],
    pulse_skip_auto_select: reg_conv[0][7:4],
    ch8_voltage_code: reg_conv[0][3:0],
    boost_voltage_code: reg_conv[1][7:4],
    ch1_enable: reg_conv[1][3],
    ch2_reference_code: reg_conv[1][2:0],
    ch3_reference_code: reg_conv[2][6:4],
    ch4_reference_code: reg_conv[2][2:0],
    ch5_voltage_code: reg_conv[3][7:4],
    ch6_voltage_code: reg_conv[3][3:0]
  };

  // ************
  // derived outputs
  // ************
  // registered so the analog side never sees decode glitches
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      backlight_ovp_level_o <= 1'b0;
      backlight_on_o <= 1'b0;
      backlight_fb_code_o <= `PMU_BL_OFF;
      ch5_ext_feedback_o <= 1'b0;
      input_power_mgmt_on_o <= 1'b0;
      cold_ratio_pct_o <= `PMU_COLD_LO;
      hot_ratio_pct_o <= `PMU_HOT_PCT;
      charge_status_pin_oe_o <= 1'b0;
      second_status_pin_oe_o <= 1'b0;
    end
    else
    begin
      backlight_ovp_level_o <= reg_ctrl[`PMU_B_OVP];
      backlight_on_o <= reg_ldo[4:0] != `PMU_BL_OFF;
      backlight_fb_code_o <= reg_ldo[4:0];
      ch5_ext_feedback_o <= reg_conv[3][7:4] == `PMU_CH5_EXT;
      input_power_mgmt_on_o <= reg_ctrl[`PMU_B_DPM] |
        (charger_type_code_i == `PMU_SDP_CODE);
      cold_ratio_pct_o <= reg_ctrl[`PMU_B_THERM_SEL] ?
        `PMU_COLD_HI : `PMU_COLD_LO;
      hot_ratio_pct_o <= `PMU_HOT_PCT;
      charge_status_pin_oe_o <= status_pin_auto_mode_i ?
        charge_state_low_i : ~reg_conv[2][`PMU_B_PIN1_LVL];
      second_status_pin_oe_o <= second_status_pin_auto_mode_i ?
        second_state_low_i : ~reg_conv[2][`PMU_B_PIN2_LVL];
    end
  end

  // status pins only pull low
  assign charge_status_pin_o = 1'b0;
  assign second_status_pin_o = 1'b0;

  // input path opens on die over-temperature and recloses after the hysteresis
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      input_path_open_o <= 1'b0;
    else if (die_over_temp_i)
      input_path_open_o <= 1'b1;
    else if (die_cooled_i)
      input_path_open_o <= 1'b0;
  end

  // battery path is never opened by the thermal loop
  assign battery_path_closed_o = 1'b1;

  // ************
  // checks
  // ************
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  AST_ADDR_IGNORE: assert property (
    (state == ST_ADDR && scl_rise && !bus_start && !bus_stop && bit_cnt == 3'h7
      && byte_in[7:1] != `PMU_I2C_ADDR) |=> state == ST_IDLE)
    else $error("foreign address not ignored");
  AST_CONV_RESET: assert property (
    conv_reset |=> reg_conv[0] == `PMU_RST_CONV0 && reg_conv[3] == `PMU_RST_CONV3)
    else $error("converter registers not reset");
  AST_CHG_RESET: assert property (
    (battery_low_i && reg_ctrl[`PMU_B_RSTC]) |=> reg_ctrl[`PMU_B_RSTP])
    else $error("charge registers not reset on battery low");
  AST_OVP: assert property (
    (wr_ctrl && !chg_reset) ##1 !chg_reset |=> backlight_ovp_level_o == $past(shreg[5], 2))
    else $error("overvoltage level not following write");
  AST_DPM: assert property (
    charger_type_code_i == `PMU_SDP_CODE |=> input_power_mgmt_on_o)
    else $error("power management not forced on");
  AST_TSD: assert property (
    thermal_shutdown_event_i |=> reg_ctrl[`PMU_B_SHUTDOWN])
    else $error("thermal shutdown flag lost");
  AST_PROT: assert property (
    protect_event_i != 8'h00 |=> (reg_prot & $past(protect_event_i)) == $past(protect_event_i))
    else $error("protection flag lost");
  AST_BL_OFF: assert property (
    reg_ldo[4:0] == `PMU_BL_OFF |=> !backlight_on_o)
    else $error("backlight on at code zero");
  AST_PIN1: assert property (
    (!status_pin_auto_mode_i && reg_conv[2][`PMU_B_PIN1_LVL]) |=> !charge_status_pin_oe_o)
    else $error("status pin driven in hi-z mode");
  AST_PIN2: assert property (
    (!second_status_pin_auto_mode_i && !reg_conv[2][`PMU_B_PIN2_LVL]) |=> second_status_pin_oe_o)
    else $error("second status pin not low");
  AST_CH5: assert property (
    reg_conv[3][7:4] == `PMU_CH5_EXT |=> ch5_ext_feedback_o)
    else $error("external feedback not selected");
  AST_DIE: assert property (
    die_over_temp_i |=> input_path_open_o && battery_path_closed_o)
    else $error("input path not opened");
  AST_WR_ACK: assert property (
    wr_pulse |-> $past(state) == ST_ACK_WR && $past(slot))
    else $error("write before byte acknowledged");

endmodule

/* tb/pmu_i2c_master.sv */
`timescale 1ns/1ps
module pmu_i2c_master
(
  // clock
  input wire logic clk_sys_i,
  // serial link, open drain data
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  // ****************************************
  // bus timing
  // ****************************************
  // quarter bit in clocks; 4 x 32 keeps the link under 400 kb/s, larger is slower
  int qtr = 32;
  // both lines released at time zero
  initial
  begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // every change lands just after a rising clock edge
  task automatic wq();
    repeat (qtr) @(posedge clk_sys_i);
  endtask
  // start or repeated start: data falls while the clock is high
  task automatic start();
    wq();
    sda_oe_o <= 1'b0;
    wq();
    scl_o <= 1'b1;
    wq();
    sda_oe_o <= 1'b1;
    wq();
    scl_o <= 1'b0;
    wq();
  endtask
  // one bit: data set in the low phase, sampled in mid high phase
  task automatic bit_x(input logic b, output logic s);
    sda_oe_o <= ~b;
    wq();
    scl_o <= 1'b1;
    wq();
    s = sda_i;
    wq();
    scl_o <= 1'b0;
    wq();
  endtask
  // stop: data rises while the clock is high
  task automatic stop();
    sda_oe_o <= 1'b1;
    wq();
    scl_o <= 1'b1;
    wq();
    sda_oe_o <= 1'b0;
    wq();
  endtask
  // one byte msb first plus the ack slot; ff releases the line for a read
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
    output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(d[i], s);
      q[i] = s;
    end
    bit_x(last, s);
    ack = ~s;
  endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import pmu_pkg::*;
;
  // ****************************************
  // signals
  // ****************************************
  // design inputs, all idle at time zero
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic int_low = 1'b0, vin_low = 1'b0, bat_low = 1'b0, en_pin = 1'b1;
  logic shut_ev = 1'b0, mode_res = 1'b0, hot_die = 1'b0, cool_die = 1'b0;
  logic auto1 = 1'b0, auto2 = 1'b0, st1 = 1'b0, st2 = 1'b0;
  logic [7:0] prot_ev = 8'h00;
  logic [2:0] charger_code = 3'h1;
  // link wires and design outputs
  logic scl, m_oe, d_oe, d_sda, sda;
  logic ovp, bl_on, ch5_ext, dpm_on, in_open, bat_closed, pin1_oe, pin2_oe;
  logic [4:0] bl_fb;
  logic [6:0] cold, hot;
  pmu_ctrl_s ctrl;
  logic [7:0] rb [8];
  logic [7:0] q;
  logic a;
  int error_cnt = 0;
  int tests_run = 0;
  // pull-up on data: low while either party pulls
  assign sda = ~(m_oe | (d_oe & ~d_sda));
  // 50 MHz system clock
  always #10 clk_sys_i = ~clk_sys_i;
  // host side of the link
  pmu_i2c_master i_m
  (
    .clk_sys_i(clk_sys_i),
    .sda_i(sda),
    .scl_o(scl),
    .sda_oe_o(m_oe)
  );
  // device under test
  pmu_regbank i_dut
  (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(d_sda),
    .sda_oe_o(d_oe),
    .internal_supply_low_i(int_low),
    .input_supply_low_i(vin_low),
    .battery_low_i(bat_low),
    .enable_pin_i(en_pin),
    .thermal_shutdown_event_i(shut_ev),
    .protect_event_i(prot_ev),
    .backlight_mode_result_i(mode_res),
    .charger_type_code_i(charger_code),
    .die_over_temp_i(hot_die),
    .die_cooled_i(cool_die),
    .status_pin_auto_mode_i(auto1),
    .second_status_pin_auto_mode_i(auto2),
    .charge_state_low_i(st1),
    .second_state_low_i(st2),
    .ctrl_o(ctrl),
    .backlight_ovp_level_o(ovp),
    .backlight_on_o(bl_on),
    .backlight_fb_code_o(bl_fb),
    .ch5_ext_feedback_o(ch5_ext),
    .input_power_mgmt_on_o(dpm_on),
    .cold_ratio_pct_o(cold),
    .hot_ratio_pct_o(hot),
    .input_path_open_o(in_open),
    .battery_path_closed_o(bat_closed),
    .charge_status_pin_o(),
    .charge_status_pin_oe_o(pin1_oe),
    .second_status_pin_o(),
    .second_status_pin_oe_o(pin2_oe)
  );
  // ****************************************
  // tasks
  // ****************************************
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // single byte write frame
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    i_m.start();
    i_m.xfer(8'h24, 1'b1, q, a);
    i_m.xfer(ofs, 1'b1, q, a);
    i_m.xfer(d, 1'b1, q, a);
    i_m.stop();
  endtask
  // set pointer, repeated start, read n bytes; nack on the last one
  task automatic rd(input logic [7:0] ofs, input int n);
    i_m.start();
    i_m.xfer(8'h24, 1'b1, q, a);
    i_m.xfer(ofs, 1'b1, q, a);
    i_m.start();
    i_m.xfer(8'h25, 1'b1, q, a);
    for (int i = 0; i < n; i++)
    begin
      i_m.xfer(8'hff, i == n - 1, rb[i], a);
    end
    i_m.stop();
  endtask
  task automatic end_sim();
    $display("checks=%0d errors=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // watchdog: the sequence needs roughly 83k cycles
  initial
  begin
    tick(95000);
    error_cnt++;
    end_sim();
  end
  // ****************************************
  // test sequence
  // ****************************************
  initial
  begin
    tick(20);
    rst_n_i <= 1'b1;
    tick(3);
    chk({ovp, dpm_on, ch5_ext, bl_on, in_open, bat_closed, pin1_oe, pin2_oe}, 8'h04);
    chk({1'b0, cold}, 8'h4a);
    chk({1'b0, hot}, 8'h1c);
    chk({ctrl.boost_voltage_code, ctrl.ch1_enable, ctrl.ch2_reference_code}, 8'ha4);
    chk({1'b0, ctrl.ch3_reference_code, 1'b0, ctrl.ch4_reference_code}, 8'h44);
    // dummy frame first; its outcome is ignored
    wr(8'h0a, 8'h00);
    rd(8'h00, 8);
    chk(rb[0], 8'h81);
    chk(rb[1], 8'h00);
    chk(rb[2], 8'h00);
    chk(rb[3], 8'hfc);
    chk(rb[4], 8'ha4);
    chk(rb[5], 8'hcc);
    chk(rb[6], 8'h83);
    chk(rb[7], 8'h00);
    // a frame for another target is neither acknowledged nor obeyed
    i_m.start();
    i_m.xfer(8'h26, 1'b1, q, a);
    i_m.xfer(8'h02, 1'b1, q, a);
    i_m.xfer(8'h1f, 1'b1, q, a);
    i_m.stop();
    chk({7'h0, a}, 8'h00);
    chk({7'h0, bl_on}, 8'h00);
    // smallest nonzero dimming code, then off
    wr(8'h02, 8'ha1);
    chk({bl_on, ctrl.backlight_enable_dimming, 2'h0}, 8'h84);
    chk({ctrl.ch5_enable, ctrl.ch6_enable, ctrl.ch8_enable, 5'h0}, 8'ha0);
    chk({3'h0, bl_fb}, 8'h01);
    wr(8'h02, 8'h00);
    chk({bl_on, 2'h0, bl_fb}, 8'h00);
    // control bits; bit4 and bit1 are not writable
    wr(8'h00, 8'hbb);
    chk({ovp, dpm_on, 6'h0}, 8'hc0);
    chk({1'b0, cold}, 8'h4a);
    shut_ev <= 1'b1;
    mode_res <= 1'b1;
    tick(1);
    shut_ev <= 1'b0;
    tick(3);
    rd(8'h00, 1);
    chk(rb[0], 8'haf);
    wr(8'h00, 8'h80);
    chk({ovp, dpm_on, 6'h0}, 8'h00);
    chk({1'b0, cold}, 8'h3c);
    charger_code <= 3'h0;
    tick(3);
    chk({7'h0, dpm_on}, 8'h01);
    charger_code <= 3'h1;
    rd(8'h00, 1);
    chk(rb[0], 8'h82);
    // sticky flags survive battery low while its policy bit is 0
    prot_ev <= 8'ha5;
    tick(1);
    prot_ev <= 8'h02;
    tick(1);
    prot_ev <= 8'h00;
    bat_low <= 1'b1;
    tick(1);
    bat_low <= 1'b0;
    tick(3);
    rd(8'h01, 1);
    chk(rb[0], 8'ha7);
    // converter registers kept on enable low while the policy bit is 0
    wr(8'h03, 8'h00);
    chk({ctrl.pulse_skip_auto_select, ctrl.ch8_voltage_code}, 8'h00);
    wr(8'h00, 8'h40);
    en_pin <= 1'b0;
    tick(1);
    en_pin <= 1'b1;
    tick(3);
    chk({ctrl.pulse_skip_auto_select, ctrl.ch8_voltage_code}, 8'h00);
    bat_low <= 1'b1;
    tick(1);
    bat_low <= 1'b0;
    tick(3);
    rd(8'h00, 2);
    chk(rb[0], 8'h83);
    chk(rb[1], 8'h00);
    en_pin <= 1'b0;
    tick(1);
    en_pin <= 1'b1;
    tick(3);
    chk({ctrl.pulse_skip_auto_select, ctrl.ch8_voltage_code}, 8'hfc);
    prot_ev <= 8'h40;
    tick(1);
    prot_ev <= 8'h00;
    vin_low <= 1'b1;
    tick(1);
    vin_low <= 1'b0;
    tick(3);
    rd(8'h01, 1);
    chk(rb[0], 8'h00);
    // external feedback code and manual status pins
    wr(8'h06, 8'h03);
    chk({ctrl.ch5_voltage_code, ctrl.ch6_voltage_code}, 8'h03);
    chk({7'h0, ch5_ext}, 8'h01);
    wr(8'h05, 8'h44);
    chk({6'h0, pin1_oe, pin2_oe}, 8'h03);
    auto1 <= 1'b1;
    auto2 <= 1'b1;
    st2 <= 1'b1;
    tick(3);
    chk({6'h0, pin1_oe, pin2_oe}, 8'h01);
    auto1 <= 1'b0;
    auto2 <= 1'b0;
    tick(3);
    chk({6'h0, pin1_oe, pin2_oe}, 8'h03);
    // slower host from here on
    i_m.qtr = 40;
    shut_ev <= 1'b1;
    tick(1);
    shut_ev <= 1'b0;
    int_low <= 1'b1;
    tick(1);
    int_low <= 1'b0;
    tick(3);
    chk({ctrl.pulse_skip_auto_select, ctrl.ch8_voltage_code}, 8'hfc);
    chk({ctrl.ch5_voltage_code, ctrl.ch6_voltage_code}, 8'h83);
    chk({5'h0, ch5_ext, pin1_oe, pin2_oe}, 8'h00);
    rd(8'h00, 1);
    chk(rb[0], 8'h83);
    // die over temperature opens only the input path
    hot_die <= 1'b1;
    tick(1);
    hot_die <= 1'b0;
    tick(3);
    chk({6'h0, in_open, bat_closed}, 8'h03);
    cool_die <= 1'b1;
    tick(1);
    cool_die <= 1'b0;
    tick(3);
    chk({6'h0, in_open, bat_closed}, 8'h01);
    end_sim();
  end
endmodule
